// [design/cfg_sink_end.sv]
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module cfg_sink_end (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [cfg_deliver_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [cfg_deliver_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  cfg_link_if.sink_mp                               link,
  output logic [cfg_deliver_pkg::WORD_W-1:0]        word_data,
  output logic                                      word_valid
);
  import cfg_deliver_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LOAD, ST_RUN} sstate_t;

  sstate_t             state_reg;
  logic [31:0]         ctrl_reg;
  logic [31:0]         words_reg;
  logic [WORD_W-1:0]   last_reg;
  logic [CNT_W-1:0]    count_reg;
  logic                skip_reg;
  logic [AXI_AW-1:0]   awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic [DIV_W-1:0]    div_cnt_reg;
  logic [2:0]          clk_s_reg;
  logic [1:0]          rw_s_reg;
  logic [1:0]          init_s_reg;
  logic [WORD_W-1:0]   dq_s1_reg;
  logic [WORD_W-1:0]   dq_s2_reg;
  logic                clk_rise;
  logic                start;
  logic [MODE_W-1:0]   mode;
  logic                master;
  logic                do_write;
  logic [DIV_W-1:0]    half;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a == OFS_CTRL || a == OFS_WORDS || a == OFS_STATUS || a == OFS_LAST;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign start    = ctrl_reg[CTRL_START];
  assign mode     = ctrl_reg[CTRL_MODE +: MODE_W];
  assign master   = (mode == MODE_MASTER_PAR) || (mode == MODE_MASTER_UP);
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // a divider below the floor would overrun the flash in master modes
  assign half     = (ctrl_reg[CTRL_DIV +: DIV_W] < DIV_W'(MASTER_HALF_MIN))
                    ? DIV_W'(MASTER_HALF_MIN) : ctrl_reg[CTRL_DIV +: DIV_W];

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    clk_s_reg  <= {clk_s_reg[1:0], link.config_clock_pin};
    rw_s_reg   <= {rw_s_reg[0], link.ready_wait};
    init_s_reg <= {init_s_reg[0], link.init_n};
    dq_s1_reg  <= link.dq;
    dq_s2_reg  <= dq_s1_reg;
  end
  assign clk_rise = clk_s_reg[1] & ~clk_s_reg[2];

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= CTRL_RESET;
      words_reg <= WORDS_RESET;
    end else if (do_write) begin
      if (awaddr_reg == OFS_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      end
      if (awaddr_reg == OFS_WORDS) begin
        words_reg <= merge(words_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= ctrl_reg;
        OFS_WORDS:  s_axi_rdata <= words_reg;
        OFS_STATUS: begin
          s_axi_rdata                    <= '0;
          s_axi_rdata[ST_DONE]           <= (state_reg == ST_RUN);
          s_axi_rdata[ST_BUSY]           <= (state_reg == ST_WAIT) || (state_reg == ST_LOAD);
          s_axi_rdata[ST_READY]          <= rw_s_reg[1];
          s_axi_rdata[ST_COUNT +: CNT_W] <= count_reg;
        end
        OFS_LAST:   s_axi_rdata <= {{(32-WORD_W){1'b0}}, last_reg};
        default:    s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // configuration sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= ST_IDLE;
      count_reg  <= '0;
      skip_reg   <= 1'b1;
      last_reg   <= '0;
      word_data  <= '0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          count_reg <= '0;
          skip_reg  <= 1'b1;
          // boundary-scan pattern leaves the port idle for debug
          if (start && mode != MODE_BSCAN) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // ready held low by a flash still in power-on delays start
          if (init_s_reg[1] && rw_s_reg[1]) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (clk_rise) begin
            // first edge only makes the flash present word zero
            skip_reg <= 1'b0;
            if (!skip_reg) begin
              word_data  <= dq_s2_reg;
              last_reg   <= dq_s2_reg;
              word_valid <= 1'b1;
              count_reg  <= count_reg + 1'b1;
              if (count_reg + 1'b1 == words_reg[CNT_W-1:0]) begin
                state_reg <= ST_RUN;
              end
            end
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
      endcase
      if (!start) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // link pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg  <= '0;
      link.config_clock_pin_o  <= 1'b0;
      link.config_clock_pin_oe <= 1'b0;
    end else begin
      // slave mode leaves the pin to the external source
      link.config_clock_pin_oe <= master && state_reg != ST_IDLE;
      if (master && state_reg != ST_IDLE && state_reg != ST_RUN) begin
        if (div_cnt_reg + 1'b1 >= half) begin
          div_cnt_reg <= '0;
          link.config_clock_pin_o <= ~link.config_clock_pin_o;
        end else begin
          div_cnt_reg <= div_cnt_reg + 1'b1;
        end
      end else begin
        div_cnt_reg <= '0;
        link.config_clock_pin_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.init_o          <= 1'b0;
      link.init_oe         <= 1'b1;
      link.mode_pins       <= MODE_SLAVE_PAR;
      link.revision_select <= '0;
      link.done            <= 1'b0;
    end else begin
      link.init_o          <= 1'b0;
      link.init_oe         <= (state_reg == ST_IDLE);
      link.mode_pins       <= mode;
      // revision select follows the CTRL_REV field of ctrl_reg every cycle in every mode; it is not latched at start
      link.revision_select <= ctrl_reg[CTRL_REV +: REV_W];
      link.done            <= (state_reg == ST_RUN);
    end
  end
endmodule // cfg_sink_end

// [design/cfg_deliver_pkg.sv]
package cfg_deliver_pkg;
  // ---------------------------------------------------------------
  // link geometry
  // ---------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 8;
  localparam int MEM_DEPTH = 256;
  localparam int REV_W     = 2;
  localparam int MODE_W    = 3;
  localparam logic [MODE_W-1:0] MODE_SLAVE_PAR  = 3'h6;
  localparam logic [MODE_W-1:0] MODE_BSCAN      = 3'h5;
  localparam logic [MODE_W-1:0] MODE_MASTER_PAR = 3'h3;
  localparam logic [MODE_W-1:0] MODE_MASTER_UP  = 3'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int POR_TIME_NS     = 2000;
  localparam int POR_CYCLES      = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASTER_MAX_MHZ  = 31;
  localparam int MASTER_HALF_MIN = (1000 + 2 * MASTER_MAX_MHZ * CLK_PERIOD_NS - 1)
                                   / (2 * MASTER_MAX_MHZ * CLK_PERIOD_NS);
  localparam int POR_CW          = 8;
  // ---------------------------------------------------------------
  // register map of the logic-device end
  // ---------------------------------------------------------------
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_WORDS  = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h8;
  localparam logic [AXI_AW-1:0] OFS_LAST   = 4'hc;
  localparam int CTRL_START  = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_REV    = 4;
  localparam int CTRL_DIV    = 8;
  localparam int DIV_W       = 8;
  localparam int ST_DONE     = 0;
  localparam int ST_BUSY     = 1;
  localparam int ST_READY    = 2;
  localparam int ST_COUNT    = 16;
  localparam int CNT_W       = 16;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0c00;
  localparam logic [31:0] WORDS_RESET = 32'h0000_0010;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// [design/cfg_link_if.sv]
`timescale 1ns/100ps
interface cfg_link_if;
  import cfg_deliver_pkg::*;
  logic                            config_clock_pin_ext;
  logic                            config_clock_pin_o;
  logic                            config_clock_pin_oe;
  logic                            config_clock_pin;
  logic                            init_o;
  logic                            init_oe;
  logic                            init_n;
  logic                            rw_o;
  logic                            rw_oe;
  logic                            ready_wait;
  logic [WORD_W-1:0]               dq_o;
  logic                            dq_oe;
  logic [WORD_W-1:0]               dq;
  logic [MODE_W-1:0]               mode_pins;
  logic [REV_W-1:0]                revision_select;
  logic                            done;
  logic                            ce_n;
  logic                            oe_n;
  logic [ADDR_W-1:0]               board_addr;
  // ---------------------------------------------------------------
  // board: pull-ups, pull-downs and straps
  // ---------------------------------------------------------------
  assign config_clock_pin = config_clock_pin_oe ? config_clock_pin_o : config_clock_pin_ext;
  assign init_n           = init_oe ? init_o : 1'b1;
  assign ready_wait       = rw_oe ? rw_o : 1'b1;
  assign dq               = dq_oe ? dq_o : '0;
  assign ce_n             = 1'b0;
  assign oe_n             = 1'b0;
  assign board_addr       = {revision_select, {(ADDR_W-REV_W){1'b0}}};

  modport flash_mp (
    input  config_clock_pin, init_n, ce_n, oe_n, board_addr,
    output rw_o, rw_oe, dq_o, dq_oe
  );
  modport sink_mp (
    input  config_clock_pin, init_n, ready_wait, dq,
    output config_clock_pin_o, config_clock_pin_oe, init_o, init_oe, mode_pins, revision_select, done
  );
endinterface

// [design/cfg_flash_end.sv]
`timescale 1ns/100ps
module cfg_flash_end (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  cfg_link_if.flash_mp                              link,
  input  wire logic                                 load_valid,
  input  wire logic [cfg_deliver_pkg::ADDR_W-1:0]   load_addr,
  input  wire logic [cfg_deliver_pkg::WORD_W-1:0]   load_data,
  input  wire logic                                 ready_wait_select_bit,
  output logic                                      burst_active,
  output logic [cfg_deliver_pkg::ADDR_W-1:0]        word_addr
);
  import cfg_deliver_pkg::*;

  typedef enum logic [1:0] {ST_POR, ST_SYNC, ST_BURST} fstate_t;

  fstate_t             state_reg;
  logic [POR_CW-1:0]   por_cnt_reg;
  logic                sel_reg;
  logic [WORD_W-1:0]   mem [MEM_DEPTH];
  logic [ADDR_W-1:0]   addr_reg;
  logic [2:0]          clk_s_reg;
  logic [1:0]          init_s_reg;
  logic [1:0]          en_s_reg;
  logic [ADDR_W-1:0]   addr_s1_reg;
  logic [ADDR_W-1:0]   addr_s2_reg;
  logic                clk_rise;
  logic                enabled;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    clk_s_reg   <= {clk_s_reg[1:0], link.config_clock_pin};
    init_s_reg  <= {init_s_reg[0], link.init_n};
    en_s_reg    <= {en_s_reg[0], ~(link.ce_n | link.oe_n)};
    addr_s1_reg <= link.board_addr;
    addr_s2_reg <= addr_s1_reg;
  end
  assign clk_rise = clk_s_reg[1] & ~clk_s_reg[2];
  assign enabled  = en_s_reg[1];

  // preload port; no reset so it maps to a ram
  always_ff @(posedge aclk) begin
    if (load_valid) begin
      mem[load_addr] <= load_data;
    end
  end

  // ---------------------------------------------------------------
  // power-on and burst sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_POR;
      por_cnt_reg <= '0;
      sel_reg     <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          sel_reg     <= ready_wait_select_bit;
          por_cnt_reg <= por_cnt_reg + 1'b1;
          if (por_cnt_reg == POR_CW'(POR_CYCLES - 1)) begin
            state_reg <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (init_s_reg[1]) begin
            state_reg <= ST_BURST;
          end
        end
        ST_BURST: begin
          // a re-asserted init restarts delivery from the strapped address
          if (!init_s_reg[1]) begin
            state_reg <= ST_SYNC;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg   <= '0;
      link.dq_o  <= '0;
    end else if (state_reg == ST_SYNC) begin
      addr_reg <= addr_s2_reg;
    end else if (state_reg == ST_BURST && clk_rise) begin
      link.dq_o <= mem[addr_reg];
      addr_reg  <= addr_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.rw_o    <= 1'b0;
      link.rw_oe   <= 1'b1;
      link.dq_oe   <= 1'b0;
      burst_active <= 1'b0;
      word_addr    <= '0;
    end else begin
      if (sel_reg) begin
        link.rw_o  <= 1'b0;
        link.rw_oe <= (state_reg == ST_POR);
      end else begin
        // wait flavour never inserts wait states, so it idles high
        link.rw_o  <= 1'b1;
        link.rw_oe <= enabled;
      end
      link.dq_oe   <= enabled && state_reg == ST_BURST;
      burst_active <= (state_reg == ST_BURST);
      word_addr    <= addr_reg;
    end
  end
endmodule // cfg_flash_end

// [dv/cfg_deliver_sva.sv]
`timescale 1ns/100ps
module cfg_deliver_sva
  import cfg_deliver_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              config_clock_pin,
  input wire logic              config_clock_pin_o,
  input wire logic              config_clock_pin_oe,
  input wire logic              init_n,
  input wire logic              ready_wait,
  input wire logic [WORD_W-1:0] dq,
  input wire logic              dq_oe,
  input wire logic [MODE_W-1:0] mode_pins,
  input wire logic              done
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [7:0] por_cnt;
  logic [7:0] half_cnt;
  logic       config_clock_pin_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) por_cnt <= 8'h00;
    else if (por_cnt != 8'hc8) por_cnt <= por_cnt + 8'h01;
  end
  // half-period length seen on the master clock, saturating
  always_ff @(posedge aclk) begin
    config_clock_pin_q <= config_clock_pin_o;
    if (!aresetn || config_clock_pin_o != config_clock_pin_q) half_cnt <= 8'h00;
    else if (half_cnt != 8'hff) half_cnt <= half_cnt + 8'h01;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_edge_word;
    $rose(config_clock_pin) && dq_oe;
  endsequence
  sequence s_init_drop;
    $fell(init_n);
  endsequence
  property p_ready_por;  por_cnt < 8'(POR_CYCLES - 2) |-> !ready_wait; endproperty
  property p_ready_up;   por_cnt == 8'(POR_CYCLES + 8) |-> ready_wait; endproperty
  property p_burst_go;   $rose(dq_oe) |-> init_n && ready_wait; endproperty
  property p_burst_stop; s_init_drop |-> ##[1:8] !dq_oe; endproperty
  property p_word_edge;  s_edge_word |-> ##[1:8] $changed(dq); endproperty
  property p_slave_clk;  mode_pins == MODE_SLAVE_PAR |-> !config_clock_pin_oe; endproperty
  property p_master_clk;
    $rose(config_clock_pin_oe) |-> mode_pins == MODE_MASTER_PAR || mode_pins == MODE_MASTER_UP;
  endproperty
  property p_half_min;
    // a phase under three aclk cycles outruns the pin synchronisers at both ends
    $changed(config_clock_pin_o) && config_clock_pin_oe && $past(config_clock_pin_oe) |-> half_cnt >= 8'h02;
  endproperty
  property p_bscan;      mode_pins == MODE_BSCAN && !init_n |=> !init_n; endproperty
  property p_done;       $rose(done) |-> init_n; endproperty
  a_ready_por:  assert property (p_ready_por) else $error("ready released during power-on");
  a_ready_up:   assert property (p_ready_up) else $error("ready not released after power-on");
  a_burst_go:   assert property (p_burst_go) else $error("burst started before both releases");
  a_burst_stop: assert property (p_burst_stop) else $error("data still driven after init low");
  a_word_edge:  assert property (p_word_edge) else $error("no new word after clock rise");
  a_slave_clk:  assert property (p_slave_clk) else $error("clock driven in slave mode");
  a_master_clk: assert property (p_master_clk) else $error("clock driven outside master modes");
  a_half_min:   assert property (p_half_min) else $error("master clock too fast");
  a_bscan:      assert property (p_bscan) else $error("boundary-scan mode started a load");
  a_done:       assert property (p_done) else $error("done without released init");
endmodule // cfg_deliver_sva

// [dv/bitstream_burst_config_delivery_tb.sv]
`timescale 1ns/100ps
module bitstream_burst_config_delivery_tb;
  import cfg_deliver_pkg::*;
  logic              aclk, aresetn, load_valid, rw_sel;
  logic [ADDR_W-1:0] load_addr, base, word_addr;
  logic [WORD_W-1:0] load_data, word_data, mem_m [MEM_DEPTH];
  logic              word_valid, ext_run, burst_active;
  logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int                n_fail, total_checks, rcv, nw, k, n;
  logic [2:0]        mode_tab [3] = '{3'h6, 3'h3, 3'h2};
  cfg_link_if link();
  cfg_flash_end u_cfg_flash_end (.aclk(aclk), .aresetn(aresetn), .link(link.flash_mp), .load_valid(load_valid),
    .load_addr(load_addr), .load_data(load_data), .ready_wait_select_bit(rw_sel),
    .burst_active(burst_active), .word_addr(word_addr));
  cfg_sink_end u_cfg_sink_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .link(link.sink_mp), .word_data(word_data), .word_valid(word_valid));
  cfg_deliver_sva u_cfg_deliver_sva (.aclk(aclk), .aresetn(aresetn), .config_clock_pin(link.config_clock_pin),
    .config_clock_pin_o(link.config_clock_pin_o), .config_clock_pin_oe(link.config_clock_pin_oe), .init_n(link.init_n), .ready_wait(link.ready_wait),
    .dq(link.dq), .dq_oe(link.dq_oe), .mode_pins(link.mode_pins), .done(link.done));
  // ---------------------------------------------------------------
  // clocks: the external link clock only runs inside a load
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    link.config_clock_pin_ext = 1'b0;
    #3;
    forever begin
      #80;
      if (ext_run || link.config_clock_pin_ext) link.config_clock_pin_ext <= ~link.config_clock_pin_ext;
    end
  end
  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    test_done();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok;
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_ok && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
      if (s_axi_bvalid) begin rs = s_axi_bresp; s_axi_bready <= 1'b0; break; end
    end
    if (i == 200) hang();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin v = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'b0; break; end
    end
    if (i == 200) hang();
  endtask
  // every captured word must follow the stored image from the start address
  always @(posedge aclk) begin
    if (aresetn && word_valid === 1'b1) begin
      chk(word_data, mem_m[base + rcv[7:0]]);
      rcv++;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(13));
    {aresetn, load_valid, ext_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {load_addr, load_data, base, rcv, n_fail, total_checks} = '0;
    s_axi_wstrb = 4'hf;
    rw_sel = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(link.ready_wait, 1'b0);
    // distinct low byte per address, so every new word differs from the last
    for (k = 0; k < MEM_DEPTH; k++) mem_m[k] = {8'($urandom) | 8'h01, 8'(k)};
    for (k = 0; k < MEM_DEPTH; k++) begin
      @(posedge aclk);
      load_valid <= 1'b1;
      load_addr <= 8'(k);
      load_data <= mem_m[k];
    end
    @(posedge aclk);
    load_valid <= 1'b0;
    chk(link.ready_wait, 1'b1);
    axi_rd(OFS_CTRL, d, r);
    chk(d, CTRL_RESET);
    axi_rd(OFS_WORDS, d, r);
    chk(d, WORDS_RESET);
    axi_rd(4'h2, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    axi_wr(4'h6, 32'h1, r);
    chk(r, RESP_SLVERR);
    axi_wr(OFS_CTRL, {28'h0, MODE_BSCAN, 1'b1}, r);
    repeat (30) @(posedge aclk);
    chk({link.init_n, link.done}, 2'h0);
    axi_wr(OFS_CTRL, 32'h0, r);
    for (k = 0; k < 3; k++) begin
      nw = 4 + $urandom % 13;
      base = {2'(k), 6'h0};
      rcv = 0;
      axi_wr(OFS_WORDS, 32'(nw), r);
      d = {16'h0, 8'(3 + $urandom % 3), 2'h0, 2'(k), mode_tab[k], 1'b1};
      axi_wr(OFS_CTRL, d, r);
      chk(r, RESP_OKAY);
      ext_run <= (mode_tab[k] == MODE_SLAVE_PAR);
      for (n = 0; n < 20000 && link.done !== 1'b1; n++) @(posedge aclk);
      if (n == 20000) hang();
      ext_run <= 1'b0;
      repeat (20) @(posedge aclk);
      chk(rcv, nw);
      chk(burst_active, 1'b1);
      // a stopped master clock leaves exactly one rise per word plus the presenting rise
      if (mode_tab[k] != MODE_SLAVE_PAR) chk(32'(word_addr), 32'(base) + 32'(nw + 1));
      axi_rd(OFS_STATUS, d, r);
      chk(d & 32'hffff_0001, {16'(nw), 16'h0001});
      axi_rd(OFS_LAST, d, r);
      chk(d, {16'h0, mem_m[base + 8'(nw - 1)]});
      axi_wr(OFS_CTRL, 32'h0, r);
      repeat (10) @(posedge aclk);
      chk({link.init_n, link.done, burst_active}, 3'h0);
    end
    test_done();
  end
endmodule // bitstream_burst_config_delivery_tb
